// File: iocd_regs.svh
// Purpose: Register offsets, reset values and fixed figures of the I/O card decode block.
// Assumes: Included by bare name from the package and the design modules.
// Notes: Offsets are byte addresses on the AHB-Lite register port.
`ifndef IOCD_REGS_SVH
`define IOCD_REGS_SVH

// Register byte offsets
`define IOCD_OFS_CFG 8'h00
`define IOCD_OFS_BRGA 8'h04
`define IOCD_OFS_BRGB 8'h08
`define IOCD_OFS_STAT 8'h0C
`define IOCD_AW 8

// Reset values
`define IOCD_CFG_RST 32'h0000_0000
`define IOCD_BRG_RST 32'h0000_000A

// Backplane address bit roles
`define IOCD_A_LOW 3
`define IOCD_A_DEV 2
`define IOCD_STRAP_N 5

// Reference clock and bus clock rates in Hz
`define IOCD_REF_HZ 3686400
`define IOCD_CLK_HZ 125000000
`define IOCD_NCO_W 32
`define IOCD_TC_W 16

`endif

// File: iocd_pkg.sv
// Purpose: Types shared by the I/O card decode block.
// Assumes: Index 1 of any two-port vector is serial port A, index 0 port B.
// Notes: Strap bits set to 1 mean the strap is installed.
package iocd_pkg;
  `include "iocd_regs.svh"

  typedef enum logic [1:0] {IOCD_DIR_IN, IOCD_DIR_OUT, IOCD_DIR_BIDIR} iocd_dir_e;

  // Strap register; addr_strap[0] guards A3, addr_strap[4] guards A7
  typedef struct packed {
    logic [11:0] rsvd;
    logic ref_ext;
    logic paper_en;
    logic [1:0] hs_inv_b;
    logic [1:0] hs_inv_a;
    iocd_dir_e dir_b;
    iocd_dir_e dir_a;
    logic [1:0] dcd_en;
    logic [1:0] sync_en;
    logic exp_strap;
    logic [4:0] addr_strap;
  } iocd_cfg_s;

  // Baud generator register
  typedef struct packed {
    logic [13:0] rsvd;
    logic use_rx;
    logic use_tx;
    logic [15:0] tc;
  } iocd_brg_s;

  typedef struct packed {
    logic [23:0] rsvd;
    logic [1:0] mismatch;
    logic paper;
    logic [1:0] carrier;
    logic [1:0] brg;
    logic hit;
  } iocd_stat_s;

  // Backplane I/O bus pins
  typedef struct packed {
    logic [7:0] addr;
    logic io_expansion_select;
    logic iorq_n;
    logic mreq_n;
    logic intack_n;
    logic rd_n;
    logic wr_n;
  } iocd_bp_s;

  // Connector lines into the card and out of it
  typedef struct packed {
    logic data;
    logic flow;
    logic ready;
    logic timing;
  } iocd_line_s;

  typedef struct packed {
    iocd_bp_s bp;
    logic ref_clk;
    iocd_line_s [1:0] line;
    logic [7:0] pa;
    logic [7:0] pb;
    logic [3:0] hs;
    logic paper_out_flag;
  } iocd_pins_s;

  typedef struct packed {
    logic ser_cs;
    logic par_cs;
    logic [2:0] reg_sel;
    logic rd;
    logic wr;
  } iocd_csel_s;

  // Serial controller side
  typedef struct packed {
    logic [1:0] rxd;
    logic [1:0] cts;
    logic [1:0] dcd;
    logic [1:0] rxc;
    logic [1:0] txc;
  } iocd_ser_o_s;

  typedef struct packed {
    logic [1:0] txd;
    logic [1:0] rts;
    logic [1:0] dtr;
  } iocd_ser_i_s;

  // Parallel/timer controller side
  typedef struct packed {
    logic [7:0] a_dat;
    logic [7:0] b_dat;
    logic a_drv;
    logic b_drv;
    logic [3:0] hs_dat;
    logic [3:0] hs_drv;
  } iocd_par_i_s;

  typedef struct packed {
    logic [7:0] a_dat;
    logic [7:0] b_dat;
    logic [3:0] hs;
    logic paper_out_flag;
  } iocd_par_o_s;

  // Parallel connector drive
  typedef struct packed {
    logic [7:0] a_dat;
    logic [7:0] a_oe;
    logic [7:0] b_dat;
    logic [7:0] b_oe;
    logic [3:0] hs_dat;
    logic [3:0] hs_oe;
  } iocd_ppin_s;
endpackage : iocd_pkg

// File: iocd_addr_decode.sv
// Purpose: Compare backplane address against straps and pick the controller register.
// Assumes: Inputs are already synchronised to hclk.
// Notes: Purely combinational; the caller registers the selects.
`timescale 1ns/1ps
`include "iocd_regs.svh"
module iocd_addr_decode import iocd_pkg::*; (
  // Synchronised backplane bus
  input iocd_bp_s bp,
  // Strap settings
  input wire logic [4:0] addr_strap,
  input wire logic exp_strap,
  // Decoded selects
  output iocd_csel_s csel
);
  // Installed strap asks for 0, open strap for 1
  function automatic logic line_match(input logic line, input logic strap);
    return line == ~strap; // R02
  endfunction : line_match

  logic match;
  logic io_cyc;

  // Block match, I/O-only qualification and register select
  always_comb begin
    match = line_match(bp.io_expansion_select, exp_strap);
    for (int i = 0; i < `IOCD_STRAP_N; i++) begin
      match = match & line_match(bp.addr[`IOCD_A_LOW + i], addr_strap[i]); // R01
    end
    io_cyc = !bp.iorq_n && bp.mreq_n && bp.intack_n; // R15
    csel.ser_cs = match && io_cyc && !bp.addr[`IOCD_A_DEV]; // R03
    csel.par_cs = match && io_cyc && bp.addr[`IOCD_A_DEV]; // R04
    csel.reg_sel = bp.addr[`IOCD_A_DEV:0];
    csel.rd = match && io_cyc && !bp.rd_n;
    csel.wr = match && io_cyc && !bp.wr_n;
  end
endmodule : iocd_addr_decode

// File: iocd_baud_gen.sv
// Purpose: One baud rate generator dividing the shared reference ticks.
// Assumes: ref_tick is a one-cycle pulse per rising reference clock edge.
// Notes: Output period is 2*(tc+1) reference periods; tc is taken at each reload.
`timescale 1ns/1ps
`include "iocd_regs.svh"
module iocd_baud_gen import iocd_pkg::*; #(
  parameter int TCW = `IOCD_TC_W
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Reference and time constant
  input wire logic ref_tick,
  input wire logic [TCW-1:0] tc,
  // Divided clock
  output logic brg_clk
);
  typedef struct packed {
    logic [TCW-1:0] cnt;
    logic out;
  } iocd_brg_st_s;

  iocd_brg_st_s r_reg;
  iocd_brg_st_s r_next;

  // Count down on reference ticks, toggle and reload at zero
  always_comb begin
    r_next = r_reg;
    if (ref_tick) begin
      if (r_reg.cnt == '0) begin
        r_next.cnt = tc; // R05
        r_next.out = ~r_reg.out;
      end else begin
        r_next.cnt = r_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign brg_clk = r_reg.out;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_reload;
    ref_tick && r_reg.cnt == '0;
  endsequence

  brg_reload_a: assert property (s_reload |=> brg_clk != $past(brg_clk) && r_reg.cnt == $past(tc)) // R05
    else $error("baud generator did not reload and toggle");
  brg_hold_a: assert property (!ref_tick |=> brg_clk == $past(brg_clk)) // R05
    else $error("baud output moved without a reference tick");
endmodule : iocd_baud_gen

// File: iocd_top.sv
// Purpose: I/O port decode, strap options and clock selection of the serial/parallel card.
// Assumes: Straps are held in a register written over AHB-Lite; pins arrive unsynchronised.
// Notes: Index 1 is serial port A (terminal side), index 0 port B (equipment side).
// Behaviour
// R01: Card answers one block of eight ports.
// R02: Installed strap needs 0, open needs 1.
// R03: A2 low selects serial controller registers.
// R04: A2 high selects parallel/timer controller registers.
// R05: Baud generators divide reference by time constant.
// R06: Baud output feeds receive, transmit or both.
// R07: Default reference clock is 3.6864 MHz.
// R08: Sync clock strap picks both serial clocks.
// R09: Carrier strap forces carrier detect present.
// R10: Port A acts terminal, port B equipment.
// R11: Strap sets parallel buffer direction per port.
// R12: Each handshake line has strap-selected inversion.
// R13: Port A group owns lines 2,3; B 0,1.
// R14: Paper-out line reaches port A only strapped.
// R15: Selects only in I/O request cycles.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "iocd_regs.svh"
module iocd_top import iocd_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite register port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Backplane, connector and strap-side pins
  input iocd_pins_s pins,
  // Controller chip selects
  output iocd_csel_s csel,
  // Serial controller side
  input iocd_ser_i_s ser_i,
  output iocd_ser_o_s ser_o,
  output iocd_line_s [1:0] line_o,
  // Parallel/timer controller side
  input iocd_par_i_s par_i,
  output iocd_par_o_s par_o,
  output iocd_ppin_s ppin
);
  localparam int PW = $bits(iocd_pins_s);
  localparam logic [63:0] NCO_INC64 = (64'(`IOCD_REF_HZ) << `IOCD_NCO_W) / 64'(`IOCD_CLK_HZ);
  localparam logic [`IOCD_NCO_W-1:0] NCO_INC = NCO_INC64[`IOCD_NCO_W-1:0];

  typedef struct packed {
    iocd_pins_s s1;
    iocd_pins_s s2;
    iocd_pins_s s3;
    iocd_pins_s filt;
    logic ref_q;
    logic [`IOCD_NCO_W-1:0] nco;
    iocd_cfg_s cfg;
    iocd_brg_s brg_a;
    iocd_brg_s brg_b;
    logic dph_wr;
    logic [`IOCD_AW-1:0] dph_addr;
    logic [31:0] rdata;
    iocd_csel_s csel;
    iocd_ser_o_s ser_o;
    iocd_line_s [1:0] line_o;
    iocd_par_o_s par_o;
    iocd_ppin_s ppin;
    logic [1:0] mis;
  } iocd_top_st_s;

  iocd_top_st_s r_reg;
  iocd_top_st_s r_next;
  iocd_csel_s dec_csel;
  logic [1:0] brg_clk;
  logic ref_tick;
  logic [`IOCD_NCO_W:0] nco_sum;

  // Buffer enable from strap direction and controller request
  function automatic logic drive_en(input iocd_dir_e dir, input logic req);
    logic en;
    en = 1'b0;
    unique case (dir)
      IOCD_DIR_IN: en = 1'b0;
      IOCD_DIR_OUT: en = 1'b1;
      IOCD_DIR_BIDIR: en = req;
      default: en = 1'b0; // Unused code behaves as input, the safe direction
    endcase
    return en;
  endfunction : drive_en

  // Strap direction disagrees with what the controller is doing
  function automatic logic dir_clash(input iocd_dir_e dir, input logic req);
    return (dir == IOCD_DIR_OUT && !req) || (dir != IOCD_DIR_OUT && dir != IOCD_DIR_BIDIR && req);
  endfunction : dir_clash

  iocd_addr_decode u_dec (
    .bp(r_reg.filt.bp),
    .addr_strap(r_reg.cfg.addr_strap),
    .exp_strap(r_reg.cfg.exp_strap),
    .csel(dec_csel)
  );

  iocd_baud_gen #(.TCW(`IOCD_TC_W)) u_brg_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .ref_tick(ref_tick),
    .tc(r_reg.brg_a.tc),
    .brg_clk(brg_clk[1])
  );

  iocd_baud_gen #(.TCW(`IOCD_TC_W)) u_brg_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .ref_tick(ref_tick),
    .tc(r_reg.brg_b.tc),
    .brg_clk(brg_clk[0])
  );

  // Reference: on-chip 3.6864 MHz accumulator by default, or the filtered pin
  assign nco_sum = {1'b0, r_reg.nco} + {1'b0, NCO_INC}; // R07
  assign ref_tick = r_reg.cfg.ref_ext ? (r_reg.filt.ref_clk && !r_reg.ref_q) : nco_sum[`IOCD_NCO_W];

  // Next state of the whole block
  always_comb begin
    logic [PW-1:0] d;
    iocd_brg_s brg;
    logic ext;
    logic [3:0] inv;
    iocd_stat_s st;
    d = '0;
    brg = '0;
    ext = 1'b0;
    inv = '0;
    st = '0;
    r_next = r_reg;
    // Three-stage synchroniser; a bit moves once stages two and three agree
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    d = r_reg.s2 ^ r_reg.s3;
    r_next.filt = iocd_pins_s'((~d & r_reg.s3) | (d & r_reg.filt));
    r_next.ref_q = r_reg.filt.ref_clk;
    r_next.nco = nco_sum[`IOCD_NCO_W-1:0];
    // Data-phase writes; reserved bits are forced to zero
    if (r_reg.dph_wr) begin
      unique case (r_reg.dph_addr)
        `IOCD_OFS_CFG: begin
          r_next.cfg = iocd_cfg_s'(hwdata);
          r_next.cfg.rsvd = '0;
        end
        `IOCD_OFS_BRGA: begin
          r_next.brg_a = iocd_brg_s'(hwdata);
          r_next.brg_a.rsvd = '0;
        end
        `IOCD_OFS_BRGB: begin
          r_next.brg_b = iocd_brg_s'(hwdata);
          r_next.brg_b.rsvd = '0;
        end
        default: ;
      endcase
    end
    // Address phase; read data comes from the updated copy so a
    // write followed at once by a read returns the new value
    r_next.dph_wr = hsel && htrans[1] && hready && hwrite;
    r_next.dph_addr = haddr[`IOCD_AW-1:0];
    st.mismatch = r_reg.mis;
    st.paper = r_reg.par_o.paper_out_flag;
    st.carrier = r_reg.ser_o.dcd;
    st.brg = brg_clk;
    st.hit = r_reg.csel.ser_cs || r_reg.csel.par_cs;
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[`IOCD_AW-1:0])
        `IOCD_OFS_CFG: r_next.rdata = 32'(r_next.cfg);
        `IOCD_OFS_BRGA: r_next.rdata = 32'(r_next.brg_a);
        `IOCD_OFS_BRGB: r_next.rdata = 32'(r_next.brg_b);
        `IOCD_OFS_STAT: r_next.rdata = 32'(st);
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
    // Chip selects
    r_next.csel = dec_csel; // R15
    // Serial ports; A faces a modem as terminal, B faces a terminal as
    // modem, so B's line inputs carry the terminal's TXD, RTS and DTR
    for (int i = 0; i < 2; i++) begin
      brg = (i == 1) ? r_reg.brg_a : r_reg.brg_b;
      ext = r_reg.filt.line[i].timing;
      r_next.ser_o.rxd[i] = r_reg.filt.line[i].data; // R10
      r_next.ser_o.cts[i] = r_reg.filt.line[i].flow; // R10
      r_next.ser_o.dcd[i] = r_reg.cfg.dcd_en[i] | r_reg.filt.line[i].ready; // R09
      if (r_reg.cfg.sync_en[i]) begin
        r_next.ser_o.rxc[i] = ext; // R08
        r_next.ser_o.txc[i] = ext; // R08
      end else begin
        r_next.ser_o.rxc[i] = brg.use_rx ? brg_clk[i] : ext; // R06
        r_next.ser_o.txc[i] = brg.use_tx ? brg_clk[i] : ext; // R06
      end
      r_next.line_o[i].data = ser_i.txd[i]; // R10
      r_next.line_o[i].flow = ser_i.rts[i];
      r_next.line_o[i].ready = ser_i.dtr[i];
      r_next.line_o[i].timing = r_reg.ser_o.txc[i];
    end
    // Parallel buffers follow the strap direction
    r_next.ppin.a_dat = par_i.a_dat;
    r_next.ppin.b_dat = par_i.b_dat;
    r_next.ppin.a_oe = {8{drive_en(r_reg.cfg.dir_a, par_i.a_drv)}}; // R11
    r_next.ppin.b_oe = {8{drive_en(r_reg.cfg.dir_b, par_i.b_drv)}}; // R11
    r_next.par_o.a_dat = r_reg.filt.pa;
    r_next.par_o.b_dat = r_reg.filt.pb;
    r_next.mis = {dir_clash(r_reg.cfg.dir_a, par_i.a_drv), dir_clash(r_reg.cfg.dir_b, par_i.b_drv)};
    // Handshake lines pass an XOR both ways
    inv = {r_reg.cfg.hs_inv_a, r_reg.cfg.hs_inv_b}; // R13
    r_next.ppin.hs_dat = par_i.hs_dat ^ inv; // R12
    r_next.ppin.hs_oe = par_i.hs_drv;
    r_next.par_o.hs = r_reg.filt.hs ^ inv; // R12
    r_next.par_o.paper_out_flag = r_reg.cfg.paper_en & r_reg.filt.paper_out_flag; // R14
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
      r_reg.cfg <= iocd_cfg_s'(`IOCD_CFG_RST);
      r_reg.brg_a <= iocd_brg_s'(`IOCD_BRG_RST);
      r_reg.brg_b <= iocd_brg_s'(`IOCD_BRG_RST);
    end else begin
      r_reg <= r_next;
    end
  end

  // Zero-wait-state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r_reg.rdata;
  assign csel = r_reg.csel;
  assign ser_o = r_reg.ser_o;
  assign line_o = r_reg.line_o;
  assign par_o = r_reg.par_o;
  assign ppin = r_reg.ppin;

  // Helper views for the checks below
  logic [7:0] bp_addr;
  logic bp_exp;
  logic bp_io;
  logic [3:0] hs_inv;
  assign bp_addr = r_reg.filt.bp.addr;
  assign bp_exp = r_reg.filt.bp.io_expansion_select;
  assign bp_io = !r_reg.filt.bp.iorq_n && r_reg.filt.bp.mreq_n && r_reg.filt.bp.intack_n;
  assign hs_inv = {r_reg.cfg.hs_inv_a, r_reg.cfg.hs_inv_b};

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_any_cs;
    csel.ser_cs || csel.par_cs;
  endsequence

  cs_io_only_a: assert property (s_any_cs |-> $past(bp_io)) // R15
    else $error("chip select outside an I/O request");
  blk_match_a: assert property (s_any_cs |-> $past(bp_addr[7:3]) == ~$past(r_reg.cfg.addr_strap)) // R02
    else $error("chip select for an address outside the strapped block");
  exp_match_a: assert property (s_any_cs |-> $past(bp_exp) == ~$past(r_reg.cfg.exp_strap)) // R01
    else $error("chip select with the expansion line mismatched");
  ser_sel_a: assert property (csel.ser_cs |-> !csel.par_cs && csel.reg_sel == $past(bp_addr[2:0]) && !csel.reg_sel[2]) // R03
    else $error("serial select with wrong register select");
  par_sel_a: assert property (csel.par_cs |-> csel.reg_sel[2] && $past(bp_addr[2])) // R04
    else $error("parallel select without A2 high");
  dcd_force_a: assert property (r_reg.cfg.dcd_en[1] |=> ser_o.dcd[1]) // R09
    else $error("carrier strap did not force carrier on port A");
  sync_clk_a: assert property (r_reg.cfg.sync_en[0] |=> ser_o.txc[0] == $past(r_reg.filt.line[0].timing) && ser_o.rxc[0] == ser_o.txc[0]) // R08
    else $error("sync strap did not route external timing");
  dir_in_a: assert property (r_reg.cfg.dir_a == IOCD_DIR_IN |=> ppin.a_oe == 8'h00) // R11
    else $error("port A buffer drives while strapped as input");
  hs_pol_a: assert property (##1 par_o.hs == ($past(r_reg.filt.hs) ^ $past(hs_inv))) // R12
    else $error("handshake line polarity wrong");
  paper_gate_a: assert property (!r_reg.cfg.paper_en |=> !par_o.paper_out_flag) // R14
    else $error("paper-out reached port A without its strap");

  // Strobe qualification, pass-through paths, buffer enables and clock choice; all but the strobe check lag their source by one edge
  sequence s_rx_from_brg;
    !r_reg.cfg.sync_en[1] && r_reg.brg_a.use_rx;
  endsequence

  sel_strobe_a: assert property (csel.rd || csel.wr |-> csel.ser_cs || csel.par_cs) // R15
    else $error("read or write strobe without a chip select");
  dcd_pass_a: assert property (!r_reg.cfg.dcd_en[0] |=> // R09
    ser_o.dcd[0] == $past(r_reg.filt.line[0].ready))
    else $error("carrier on port B did not follow the connector");
  rx_pass_a: assert property (##1 ser_o.rxd == // R10
    {$past(r_reg.filt.line[1].data), $past(r_reg.filt.line[0].data)})
    else $error("receive data did not follow the connector");
  brg_rx_sel_a: assert property (s_rx_from_brg |=> ser_o.rxc[1] == $past(brg_clk[1])) // R06
    else $error("port A receive clock did not come from its baud generator");
  dir_out_a: assert property (r_reg.cfg.dir_a == IOCD_DIR_OUT |=> ppin.a_oe == 8'hFF) // R11
    else $error("port A buffer idle while strapped as output");
  dir_bidir_a: assert property (r_reg.cfg.dir_b == IOCD_DIR_BIDIR |=> // R11
    ppin.b_oe == {8{$past(par_i.b_drv)}})
    else $error("port B buffer ignored the controller in both-way mode");
  hs_out_a: assert property (##1 ppin.hs_dat == ($past(par_i.hs_dat) ^ $past(hs_inv))) // R12
    else $error("outgoing handshake polarity wrong");
  paper_pass_a: assert property (r_reg.cfg.paper_en |=> // R14
    par_o.paper_out_flag == $past(r_reg.filt.paper_out_flag))
    else $error("paper-out did not reach port A with its strap");
endmodule : iocd_top

// File: iocd_host_model.sv
// Purpose: Host CPU model driving backplane I/O, memory and acknowledge cycles.
// Assumes: Tasks are called just after a rising hclk edge.
// Notes: A released address shows the inverse of its last value; strobes idle high.
`timescale 1ns/1ps
module iocd_host_model import iocd_pkg::*; (
  // Bus clock
  input wire logic hclk,
  // Backplane drive
  output iocd_bp_s bp
);
  // Idle bus at time zero, address pattern arbitrary
  initial begin
    bp = '{addr: 8'h5A, io_expansion_select: 1'b1, iorq_n: 1'b1, mreq_n: 1'b1,
      intack_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
  end

  // Kind 0 I/O request, 1 memory request, 2 interrupt acknowledge
  task start(input int kind, input logic [7:0] a, input logic e, input logic wr);
    bp.addr <= a;
    bp.io_expansion_select <= e;
    bp.iorq_n <= (kind == 1);
    bp.mreq_n <= (kind != 1);
    bp.intack_n <= (kind != 2);
    bp.rd_n <= (kind == 2) | wr;
    bp.wr_n <= (kind == 2) | ~wr;
  endtask : start

  // Release; stale lines flip so a lingering decode cannot pass by luck
  task stop;
    bp.addr <= ~bp.addr;
    bp.io_expansion_select <= ~bp.io_expansion_select;
    bp.iorq_n <= 1'b1;
    bp.mreq_n <= 1'b1;
    bp.intack_n <= 1'b1;
    bp.rd_n <= 1'b1;
    bp.wr_n <= 1'b1;
  endtask : stop
endmodule : iocd_host_model

// File: testbench.sv
// Purpose: Self-checking bench for the I/O card decode block.
// Assumes: Zero-wait AHB-Lite slave; pins reach outputs five edges after a change.
// Notes: Expected results are queued by the drivers and compared by one watcher, except toggle counts, which tog_count checks itself.
`timescale 1ns/1ps
`include "iocd_regs.svh"
module testbench import iocd_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, mon_go, paper_v;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [4:0] strap;
  logic exp_s;
  logic [7:0] pa_v;
  logic [3:0] hs_v;
  int err_total, checks, seed, i;
  int sel_q[$];
  logic [31:0] val_q[$];
  iocd_bp_s host_bp;
  iocd_line_s [1:0] line_v, line_o;
  iocd_pins_s pins;
  iocd_csel_s csel;
  iocd_ser_i_s ser_i;
  iocd_par_i_s par_i;
  iocd_ser_o_s ser_o;
  iocd_par_o_s par_o;
  iocd_ppin_s ppin;
  iocd_cfg_s c;
  iocd_brg_s bw;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  assign pins = '{bp: host_bp, ref_clk: 1'b0, line: line_v, pa: pa_v, pb: ~pa_v,
    hs: hs_v, paper_out_flag: paper_v};

  iocd_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins), .csel(csel),
    .ser_i(ser_i), .ser_o(ser_o), .line_o(line_o), .par_i(par_i), .par_o(par_o),
    .ppin(ppin));

  iocd_host_model host (.hclk(hclk), .bp(host_bp));

  // Bus clock, 8 ns
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask : check

  task final_report;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // Output chosen by a queued note; unselected register fields masked
  function automatic logic [31:0] probe(input int s);
    case (s)
      0: probe = hrdata;
      1: probe = {25'h0, csel.ser_cs, csel.par_cs,
        (csel.ser_cs | csel.par_cs) ? csel.reg_sel : 3'h0, csel.rd, csel.wr};
      2: probe = {27'h0, par_o.hs, par_o.paper_out_flag};
      3: probe = {25'h0, line_o[1].flow, line_o[0].flow, line_o[1].ready, line_o[0].ready,
        ser_o.dcd[1], line_o[1].data, line_o[0].data};
      4: probe = {30'h0, ser_o.rxc[1], ser_o.txc[1]};
      5: probe = {par_o.a_dat, par_o.b_dat, 11'h0, hresp, ser_o.rxd, ser_o.cts};
      default: probe = {ppin.a_dat, ppin.a_oe, ppin.b_oe, ppin.hs_dat, ppin.hs_oe};
    endcase
  endfunction : probe

  // Watcher takes the oldest note whenever a result is flagged
  always @(posedge hclk) begin
    if (mon_go) begin
      check(probe(sel_q.pop_front()), val_q.pop_front());
    end
  end

  // Bounded wait for the slave ready
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        final_report;
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  // One AHB-Lite word transfer; a read queues its expected data
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? d : ~d;
    if (!wr) begin
      sel_q.push_back(0);
      val_q.push_back(d);
      mon_go <= 1'b1;
    end
    wait_rdy;
    mon_go <= 1'b0;
  endtask : ahb

  // Let pins pass the synchroniser, then flag one compare
  task settle(input int s, input logic [31:0] v);
    repeat (6) @(posedge hclk);
    sel_q.push_back(s);
    val_q.push_back(v);
    mon_go <= 1'b1;
    @(posedge hclk);
    mon_go <= 1'b0;
  endtask : settle

  // One backplane cycle and its expected selects
  task dec(input int kind, input logic [7:0] a, input logic e, input logic wr);
    logic hit;
    hit = (kind == 0) && (a[7:3] === ~strap) && (e === ~exp_s);
    host.start(kind, a, e, wr);
    settle(1, {25'h0, hit & ~a[2], hit & a[2], hit ? a[2:0] : 3'h0, hit & ~wr, hit & wr});
    host.stop;
    repeat (6) @(posedge hclk);
  endtask : dec

  // Toggles of the port A transmit clock over a fixed span, sampled off-edge
  task tog_count(input int e);
    int n;
    logic last;
    n = 0;
    repeat (300) @(negedge hclk);
    last = ser_o.txc[1];
    repeat (6782) begin
      @(negedge hclk);
      if (ser_o.txc[1] !== last) n++;
      last = ser_o.txc[1];
    end
    @(posedge hclk);
    check(32'(n >= e - 2 && n <= e + 2), 32'h1);
  endtask : tog_count

  // Hang guard
  initial begin
    repeat (100000) @(posedge hclk);
    err_total++;
    final_report;
  end

  // Main sequence
  initial begin
    seed = 32'h4A634A39;
    err_total = 0;
    checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    mon_go = 1'b0;
    ser_i = '0;
    par_i = '0;
    line_v = '0;
    hs_v = 4'h0;
    paper_v = 1'b1;
    r = $random(seed);
    pa_v = r[7:0];
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, `IOCD_OFS_CFG, `IOCD_CFG_RST);
    ahb(0, `IOCD_OFS_BRGA, `IOCD_BRG_RST);
    ahb(0, `IOCD_OFS_BRGB, `IOCD_BRG_RST);
    ahb(1, 8'h14, 32'hFFFFFFFF);
    ahb(0, 8'h14, 32'h0);
    // Random strap setting for the address block
    r = $random(seed);
    strap = r[4:0];
    exp_s = r[5];
    c = '0;
    c.addr_strap = strap;
    c.exp_strap = exp_s;
    ahb(1, `IOCD_OFS_CFG, c);
    ahb(0, `IOCD_OFS_CFG, c);
    for (i = 0; i < 8; i++) dec(0, {~strap, i[2:0]}, ~exp_s, i[0]);
    for (i = 0; i < 5; i++) dec(0, {~strap ^ 5'(1 << i), 3'h5}, ~exp_s, 1'b0);
    dec(0, {~strap, 3'h2}, exp_s, 1'b0);
    dec(1, {~strap, 3'h2}, ~exp_s, 1'b0);
    dec(2, {~strap, 3'h6}, ~exp_s, 1'b0);
    // Handshake inversion, paper gate, carrier strap, port data lines
    c.hs_inv_a = 2'b11;
    c.hs_inv_b = 2'b01;
    c.dcd_en = 2'b10;
    ahb(1, `IOCD_OFS_CFG, c);
    r = $random(seed);
    ser_i <= iocd_ser_i_s'(r[5:0]);
    settle(2, {27'h0, 4'hD, 1'b0});
    settle(3, {25'h0, r[3:2], r[1:0], 1'b1, r[5:4]});
    c.paper_en = 1'b1;
    c.dir_a = IOCD_DIR_OUT;
    c.dir_b = IOCD_DIR_BIDIR;
    ahb(1, `IOCD_OFS_CFG, c);
    hs_v <= 4'hF;
    r = $random(seed);
    pa_v <= r[15:8];
    line_v <= r[7:0];
    par_i <= iocd_par_i_s'(r[25:0]);
    settle(2, {27'h0, 4'h2, 1'b1});
    settle(5, {r[15:8], ~r[15:8], 12'h0, r[7], r[3], r[6], r[2]});
    settle(6, {r[25:18], 8'hFF, {8{r[8]}}, r[7:4] ^ 4'hD, r[3:0]});
    // Sync clock strap overrides a running baud generator on both clocks
    bw = '0;
    bw.use_tx = 1'b1;
    bw.use_rx = 1'b1;
    bw.tc = 16'h1;
    ahb(1, `IOCD_OFS_BRGA, bw);
    c.sync_en = 2'b11;
    ahb(1, `IOCD_OFS_CFG, c);
    line_v[1].timing <= 1'b1;
    settle(4, 32'h3);
    line_v[1].timing <= 1'b0;
    settle(4, 32'h0);
    // Baud generator on both clocks of port A; toggles counted on the transmit clock only
    c.sync_en = 2'b00;
    ahb(1, `IOCD_OFS_CFG, c);
    ahb(0, `IOCD_OFS_BRGA, bw);
    tog_count(100);
    bw.tc = 16'h4;
    ahb(1, `IOCD_OFS_BRGA, bw);
    tog_count(40);
    final_report;
  end
endmodule : testbench
